// ### design/mtx_tx_config_status.sv
// Contract
// - loopback select bits reset to zero
// - crc inhibit bit clear appends crc
// - crc inhibit works in every loopback mode
// - two-bit loopback field selects four modes
// - loopback pin high only in mode 10
// - hash 62 disables, hash 63 enables transmitter
// - clearing auto disable re-enables transmitter
// - offset mode widens first three backoffs
// - offset clear gives standard backoff
// - status cleared when next transmission starts
// - sent-ok only without abort or underrun
// - collided bit set, collisions counted
// - sixteen attempts abort and flag it
// - carrier loss flagged, frame continues
// - fifo empty without bus: underrun abort
// - no heartbeat in 6.4 us flags
// - collision after slot time flagged late
// - data config bit three gates loopback
//
// The address-and-strobe port is this design's own decision.
module mtx_tx_config_status #(
    parameter int SLOT_CYCLES = mtx_pkg::SLOT_CYCLES,
    parameter int HB_CYCLES = mtx_pkg::HB_CYCLES
) (
    input wire logic clk_sys, // system clock, 125 MHz
    input wire logic srst, // synchronous reset, active high
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // register write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    input wire logic loopback_select_enable, // data config bit three, low selects loopback
    input wire logic tx_start, // host initiates a transmission
    input wire logic frame_end, // serializer finished the frame
    input wire logic collision, // collision seen during the attempt
    input wire logic carrier_sense, // carrier level while sending
    input wire logic fifo_empty, // transmit fifo ran empty
    input wire logic bus_grant, // bus held by the dma
    input wire logic cd_heartbeat, // collision signal from transceiver
    input wire logic mc_hash_valid, // multicast frame received
    input wire logic [5:0] mc_hash_index, // its hash filter bit
    output logic crc_append, // append crc to frames
    output logic [1:0] loopback_mode, // effective loopback mode
    output logic loopback_output_pin, // loopback pin
    output logic tx_enable, // transmitter enabled
    output logic tx_busy, // transmission in progress
    output logic retry, // pulse: start next attempt
    output logic tx_abort, // pulse: drop the frame
    output logic tx_done, // pulse: transmission finished
    output logic [9:0] backoff_slots // slot times left of the chosen backoff, counting down
);

    typedef struct packed {
        mtx_pkg::mtx_state_t st;
        logic [mtx_pkg::CFG_W-1:0] cfg;
        logic [7:0] stat;
        logic [mtx_pkg::CNT_W-1:0] coll_cnt;
        logic [mtx_pkg::CNT_W-1:0] attempts;
        logic [7:0] rdata;
        logic tx_dis;
        logic [mtx_pkg::TMR_W-1:0] elapsed;
        logic [mtx_pkg::TMR_W-1:0] tmr;
        logic [9:0] bo_slots;
        logic [15:0] lfsr;
        logic carrier_prev;
        logic retry;
        logic abort;
        logic done;
        logic crc_append;
        logic [1:0] lb_mode;
        logic lb_pin;
        logic tx_en;
    } mtx_regs_t;

    mtx_regs_t s_r;
    mtx_regs_t s_nxt;

    // mask of the backoff draw for collision number n
    function automatic logic [9:0] bo_mask(input logic [mtx_pkg::CNT_W-1:0] n,
                                           input logic offset_on);
        int e;
        e = int'(n);
        if (offset_on && n <= mtx_pkg::OFFSET_COLLISIONS)
        begin
            e = e + mtx_pkg::OFFSET_EXTRA;
        end
        if (e > mtx_pkg::BACKOFF_EXP_MAX)
        begin
            e = mtx_pkg::BACKOFF_EXP_MAX;
        end
        bo_mask = 10'((11'h001 << e) - 11'h001);
    endfunction

    logic cfg_wr;
    logic [mtx_pkg::CNT_W-1:0] coll_inc;
    logic [mtx_pkg::TMR_W-1:0] slot_last;
    logic [mtx_pkg::TMR_W-1:0] hb_last;
    assign cfg_wr = reg_wr && reg_addr == mtx_pkg::OFF_TX_CONFIG;
    assign coll_inc = s_r.coll_cnt + 5'h01;
    assign slot_last = mtx_pkg::TMR_W'(SLOT_CYCLES - 1);
    assign hb_last = mtx_pkg::TMR_W'(HB_CYCLES - 1);

    // next-state logic for the whole block
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.retry = 1'b0;
        s_nxt.abort = 1'b0;
        s_nxt.done = 1'b0;
        s_nxt.rdata = 8'h00;
        s_nxt.lfsr = {s_r.lfsr[14:0], s_r.lfsr[15] ^ s_r.lfsr[13] ^ s_r.lfsr[12] ^ s_r.lfsr[10]};

        // upper three bits of the written byte are reserved and dropped
        if (cfg_wr)
        begin
            s_nxt.cfg = reg_wdata[mtx_pkg::CFG_W-1:0];
        end

        // read data stand one cycle after the strobe
        if (reg_rd)
        begin
            case (reg_addr)
                mtx_pkg::OFF_TX_STATUS: s_nxt.rdata = s_r.stat & 8'hfd;
                mtx_pkg::OFF_COLL_COUNT: s_nxt.rdata = {3'h0, s_r.coll_cnt};
                default: s_nxt.rdata = 8'h00;
            endcase
        end

        // remote disable by special multicast, software clear wins back
        if (!s_nxt.cfg[mtx_pkg::CFG_AUTO_DIS])
        begin
            s_nxt.tx_dis = 1'b0;
        end
        else if (mc_hash_valid && mc_hash_index == mtx_pkg::HASH_DISABLE)
        begin
            s_nxt.tx_dis = 1'b1;
        end
        else if (mc_hash_valid && mc_hash_index == mtx_pkg::HASH_ENABLE)
        begin
            s_nxt.tx_dis = 1'b0;
        end

        // transmit sequencing and status capture
        case (s_r.st)
            mtx_pkg::ST_IDLE:
            begin
                if (tx_start && s_r.tx_en)
                begin
                    s_nxt.stat = mtx_pkg::STAT_RESET;
                    s_nxt.coll_cnt = '0;
                    s_nxt.attempts = 5'h01;
                    s_nxt.elapsed = '0;
                    s_nxt.carrier_prev = carrier_sense;
                    s_nxt.st = mtx_pkg::ST_SEND;
                end
            end
            mtx_pkg::ST_SEND:
            begin
                s_nxt.carrier_prev = carrier_sense;
                if (s_r.elapsed <= slot_last)
                begin
                    s_nxt.elapsed = s_r.elapsed + 16'h0001;
                end
                // carrier loss only flags; the frame runs on
                if (s_r.carrier_prev && !carrier_sense)
                begin
                    s_nxt.stat[mtx_pkg::STAT_CARRIER_LOST] = 1'b1;
                end
                if (fifo_empty && !bus_grant)
                begin
                    s_nxt.stat[mtx_pkg::STAT_UNDERRUN] = 1'b1;
                    s_nxt.abort = 1'b1;
                    s_nxt.done = 1'b1;
                    s_nxt.st = mtx_pkg::ST_IDLE;
                end
                else if (collision)
                begin
                    s_nxt.stat[mtx_pkg::STAT_COLLIDED] = 1'b1;
                    s_nxt.coll_cnt = coll_inc;
                    // late collisions go through the same backoff path
                    if (s_r.elapsed > slot_last)
                    begin
                        s_nxt.stat[mtx_pkg::STAT_LATE_COLL] = 1'b1;
                    end
                    if (s_r.attempts == mtx_pkg::MAX_ATTEMPTS)
                    begin
                        s_nxt.stat[mtx_pkg::STAT_ABORTED] = 1'b1;
                        s_nxt.abort = 1'b1;
                        s_nxt.done = 1'b1;
                        s_nxt.st = mtx_pkg::ST_IDLE;
                    end
                    else
                    begin
                        s_nxt.bo_slots = s_r.lfsr[9:0] & bo_mask(coll_inc,
                                                 s_r.cfg[mtx_pkg::CFG_COLL_OFFSET]);
                        s_nxt.attempts = s_r.attempts + 5'h01;
                        s_nxt.tmr = '0;
                        s_nxt.st = mtx_pkg::ST_BACKOFF;
                    end
                end
                else if (frame_end)
                begin
                    s_nxt.stat[mtx_pkg::STAT_SENT_OK] = 1'b1;
                    s_nxt.tmr = '0;
                    s_nxt.st = mtx_pkg::ST_HBEAT;
                end
            end
            mtx_pkg::ST_BACKOFF:
            begin
                if (s_r.bo_slots == 10'h000)
                begin
                    s_nxt.retry = 1'b1;
                    s_nxt.elapsed = '0;
                    s_nxt.carrier_prev = carrier_sense;
                    s_nxt.st = mtx_pkg::ST_SEND;
                end
                else if (s_r.tmr == slot_last)
                begin
                    s_nxt.tmr = '0;
                    s_nxt.bo_slots = s_r.bo_slots - 10'h001;
                end
                else
                begin
                    s_nxt.tmr = s_r.tmr + 16'h0001;
                end
            end
            mtx_pkg::ST_HBEAT:
            begin
                if (cd_heartbeat)
                begin
                    s_nxt.done = 1'b1;
                    s_nxt.st = mtx_pkg::ST_IDLE;
                end
                else if (s_r.tmr == hb_last)
                begin
                    s_nxt.stat[mtx_pkg::STAT_HB_FAIL] = 1'b1;
                    s_nxt.done = 1'b1;
                    s_nxt.st = mtx_pkg::ST_IDLE;
                end
                else
                begin
                    s_nxt.tmr = s_r.tmr + 16'h0001;
                end
            end
            default:
            begin
                s_nxt.st = mtx_pkg::ST_IDLE;
            end
        endcase

        // crc control is independent of the loopback field
        s_nxt.crc_append = !s_nxt.cfg[mtx_pkg::CFG_CRC_INHIBIT];
        // loopback only acts while the data config bit selects it
        s_nxt.lb_mode = loopback_select_enable ? mtx_pkg::LB_NORMAL
                      : s_nxt.cfg[mtx_pkg::CFG_LB_HIGH:mtx_pkg::CFG_LB_LOW];
        s_nxt.lb_pin = s_nxt.lb_mode == mtx_pkg::LB_ENDEC;
        s_nxt.tx_en = !s_nxt.tx_dis;
    end

    // single state register
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            s_r <= '0;
            s_r.st <= mtx_pkg::ST_IDLE;
            s_r.cfg <= mtx_pkg::CFG_RESET;
            s_r.stat <= mtx_pkg::STAT_RESET;
            s_r.lfsr <= mtx_pkg::LFSR_SEED;
            s_r.crc_append <= 1'b1;
            s_r.tx_en <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign crc_append = s_r.crc_append;
    assign loopback_mode = s_r.lb_mode;
    assign loopback_output_pin = s_r.lb_pin;
    assign tx_enable = s_r.tx_en;
    assign tx_busy = s_r.st != mtx_pkg::ST_IDLE;
    assign retry = s_r.retry;
    assign tx_abort = s_r.abort;
    assign tx_done = s_r.done;
    assign backoff_slots = s_r.bo_slots;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    sequence s_send_start;
        s_r.st == mtx_pkg::ST_IDLE && tx_start && s_r.tx_en;
    endsequence

    sequence s_last_try_collides;
        s_r.st == mtx_pkg::ST_SEND && !(fifo_empty && !bus_grant) && collision
            && s_r.attempts == mtx_pkg::MAX_ATTEMPTS;
    endsequence

    // the default disable would switch this check off exactly when reset is high
    lb_reset_zero_a: assert property (@(posedge clk_sys) disable iff (1'b0)
        srst |=> loopback_mode == 2'h0
        && !loopback_output_pin)
        else $error("loopback not normal after reset");

    crc_follow_a: assert property (cfg_wr |=> crc_append == !$past(reg_wdata[0]))
        else $error("crc append does not follow written inhibit bit");

    lb_pin_mode_a: assert property (loopback_output_pin == (loopback_mode == 2'h2))
        else $error("loopback pin disagrees with mode");

    lb_gate_a: assert property (loopback_select_enable |=> loopback_mode == 2'h0)
        else $error("loopback active while data config selects normal");

    auto_disable_a: assert property (s_r.cfg[3] && !cfg_wr
        && mc_hash_valid && mc_hash_index == 6'h3e |=> !tx_enable)
        else $error("hash 62 did not disable transmitter");

    auto_clear_a: assert property (cfg_wr && !reg_wdata[3] |=> tx_enable)
        else $error("clearing auto disable left transmitter off");

    status_clear_a: assert property (s_send_start |=> s_r.stat == 8'h00 && tx_busy)
        else $error("status not cleared at transmission start");

    abort_sixteen_a: assert property (s_last_try_collides |=> tx_abort && tx_done
        && s_r.stat[3] && !s_r.stat[0] ##1 !tx_busy)
        else $error("sixteenth attempt did not abort");

    underrun_abort_a: assert property (s_r.st == mtx_pkg::ST_SEND && fifo_empty && !bus_grant
        |=> tx_abort && s_r.stat[5] && !tx_busy)
        else $error("underrun did not abort");

    heartbeat_fail_a: assert property (s_r.st == mtx_pkg::ST_HBEAT && s_r.tmr == hb_last
        && !cd_heartbeat |=> s_r.stat[6] && tx_done)
        else $error("missing heartbeat not flagged");

    backoff_range_a: assert property (s_r.st == mtx_pkg::ST_SEND && !fifo_empty && collision
        && s_r.attempts < mtx_pkg::MAX_ATTEMPTS && !s_r.cfg[4] && s_r.coll_cnt == 5'h00
        |=> backoff_slots <= 10'h001)
        else $error("first standard backoff out of range");

    status_bit1_a: assert property (reg_rd && reg_addr == 8'h04 |=> !reg_rdata[1])
        else $error("reserved status bit read as one");

endmodule // mtx_tx_config_status

// ### inc/mtx_pkg.sv
package mtx_pkg;
    // register offsets on the plain register port
    localparam logic [7:0] OFF_TX_STATUS = 8'h04; // transmit_event_status, read
    localparam logic [7:0] OFF_COLL_COUNT = 8'h05; // collision_count_register, read
    localparam logic [7:0] OFF_TX_CONFIG = 8'h0d; // transmit_configuration, write

    // transmit_configuration field positions
    localparam int CFG_CRC_INHIBIT = 0;
    localparam int CFG_LB_LOW = 1; // loopback_select_low
    localparam int CFG_LB_HIGH = 2; // loopback_select_high
    localparam int CFG_AUTO_DIS = 3; // auto_transmit_disable
    localparam int CFG_COLL_OFFSET = 4; // collision_offset_enable
    localparam int CFG_W = 5; // bits 7..5 are reserved and not stored
    localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;

    // transmit_event_status field positions
    localparam int STAT_SENT_OK = 0; // packet_sent_ok
    localparam int STAT_COLLIDED = 2;
    localparam int STAT_ABORTED = 3; // transmit_aborted
    localparam int STAT_CARRIER_LOST = 4; // carrier_lost
    localparam int STAT_UNDERRUN = 5; // fifo_underrun
    localparam int STAT_HB_FAIL = 6; // heartbeat_fail
    localparam int STAT_LATE_COLL = 7;
    localparam logic [7:0] STAT_RESET = 8'h00;

    // loopback modes
    localparam logic [1:0] LB_NORMAL = 2'h0;
    localparam logic [1:0] LB_CORE = 2'h1;
    localparam logic [1:0] LB_ENDEC = 2'h2;
    localparam logic [1:0] LB_EXTERNAL = 2'h3;

    // multicast hash bits that steer the transmitter
    localparam logic [5:0] HASH_DISABLE = 6'h3e; // filter bit 62
    localparam logic [5:0] HASH_ENABLE = 6'h3f; // filter bit 63

    // collision handling
    localparam logic [4:0] MAX_ATTEMPTS = 5'h10; // 16 attempts, original included
    localparam logic [4:0] OFFSET_COLLISIONS = 5'h03;
    localparam int OFFSET_EXTRA = 3;
    localparam int BACKOFF_EXP_MAX = 10;
    localparam int CNT_W = 5;
    localparam int TMR_W = 16;

    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int SLOT_TIME_NS = 51200; // 51.2 us
    localparam int HB_WINDOW_NS = 6400; // 6.4 us
    localparam int SLOT_CYCLES = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HB_CYCLES = HB_WINDOW_NS / CLK_PERIOD_NS;

    localparam logic [15:0] LFSR_SEED = 16'hace1;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEND,
        ST_BACKOFF,
        ST_HBEAT
    } mtx_state_t;
endpackage

// ### tb/mtx_net_model.sv
module mtx_net_model (
    input wire logic clk_sys, // system clock
    input wire logic srst, // synchronous reset, active high
    input wire logic tx_busy, // transmission in progress
    input wire logic retry, // start of a new attempt after backoff
    input wire logic [4:0] n_coll, // collisions to inflict on the next frame
    input wire logic hb_on, // transceiver answers with a heartbeat
    input wire logic carrier_drop, // carrier falls while the frame goes out
    input wire logic late, // long attempts so that collisions land late
    output logic frame_end, // frame fully serialized
    output logic collision, // collision seen on the medium
    output logic carrier_sense, // carrier level
    output logic cd_heartbeat // heartbeat from the transceiver
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_q;
    logic act;
    logic [4:0] left;
    logic [3:0] cnt;
    logic [2:0] hb;

    // carrier follows the transfer; a drop mid-send must not end the frame
    assign carrier_sense = tx_busy && !(carrier_drop && act && cnt >= 4'h2);

    // one attempt per start or retry: collide while the budget lasts, else finish
    always @(posedge clk_sys)
    begin
        busy_q <= tx_busy;
        frame_end <= 1'b0;
        collision <= 1'b0;
        hb <= (hb == 3'h0 || hb == 3'h5) ? 3'h0 : hb + 3'h1;
        cd_heartbeat <= hb_on && (hb == 3'h2 || hb == 3'h3);
        if (srst || !tx_busy)
        begin
            act <= 1'b0;
            cnt <= 4'h0;
            left <= n_coll;
        end
        else if (!busy_q || retry)
        begin
            act <= 1'b1;
            cnt <= 4'h0;
        end
        else if (act)
        begin
            cnt <= cnt + 4'h1;
            // long attempts push the collision past the shortened slot time
            if (cnt == (late ? 4'hc : 4'h3))
            begin
                act <= 1'b0;
                if (left != 5'h0)
                begin
                    collision <= 1'b1;
                    left <= left - 5'h1;
                end
                else
                begin
                    frame_end <= 1'b1;
                    hb <= 3'h1;
                end
            end
        end
        if (srst)
            hb <= 3'h0;
    end
endmodule // mtx_net_model

// ### tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, tx_start = 1'b0, fifo_empty = 1'b0;
    logic loopback_select_enable = 1'b1, bus_grant = 1'b1, mc_hash_valid = 1'b0;
    logic [5:0] mc_hash_index = 6'h00;
    logic [4:0] n_coll = 5'h00;
    logic hb_on = 1'b1, carrier_drop = 1'b0, late = 1'b0;
    logic frame_end, collision, carrier_sense, cd_heartbeat, crc_append;
    logic loopback_output_pin, tx_enable, tx_busy, retry, tx_abort, tx_done;
    logic [1:0] loopback_mode;
    logic [9:0] backoff_slots, mx_seen;
    int n_fail = 0;
    int checks = 0;

    always #4 clk_sys = ~clk_sys;

    // slot and heartbeat counts shortened so that long backoffs stay cheap
    mtx_tx_config_status #(.SLOT_CYCLES(8), .HB_CYCLES(4)) dut_u (.clk_sys, .srst,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .loopback_select_enable,
        .tx_start, .frame_end, .collision, .carrier_sense, .fifo_empty, .bus_grant,
        .cd_heartbeat, .mc_hash_valid, .mc_hash_index, .crc_append, .loopback_mode,
        .loopback_output_pin, .tx_enable, .tx_busy, .retry, .tx_abort, .tx_done,
        .backoff_slots);

    mtx_net_model net_u (.clk_sys, .srst, .tx_busy, .retry, .n_coll, .hb_on, .carrier_drop,
        .late, .frame_end, .collision, .carrier_sense, .cd_heartbeat);

    task automatic report_and_stop;
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask

    // register port: one-cycle strobes, read data only in the following cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic hash(input logic [5:0] h);
        @(posedge clk_sys);
        mc_hash_valid <= 1'b1;
        mc_hash_index <= h;
        @(posedge clk_sys);
        mc_hash_valid <= 1'b0;
        #1;
    endtask

    // one frame through the medium model, then status and count as software sees them
    task automatic frame(input logic [4:0] nc, input logic [2:0] kn, input logic und,
        input logic [7:0] est, input logic [7:0] ecnt);
        logic [7:0] v;
        logic ab;
        int i;
        n_coll <= nc;
        {hb_on, carrier_drop, late} <= kn;
        @(posedge clk_sys);
        tx_start <= 1'b1;
        @(posedge clk_sys);
        tx_start <= 1'b0;
        fifo_empty <= und;
        bus_grant <= !und;
        mx_seen = 10'h000;
        ab = 1'b0;
        // long enough for sixteen attempts with their backoffs
        for (i = 0; i < 60000 && tx_done !== 1'b1; i++)
        begin
            tick();
            if (backoff_slots > mx_seen)
                mx_seen = backoff_slots;
            ab = ab | (tx_abort === 1'b1);
        end
        if (i == 60000)
        begin
            n_fail++;
            report_and_stop();
        end
        fifo_empty <= 1'b0;
        bus_grant <= 1'b1;
        rd(mtx_pkg::OFF_TX_STATUS, v);
        chk(10'(v), 10'(est));
        chk(10'(ab), 10'(est[mtx_pkg::STAT_ABORTED] | est[mtx_pkg::STAT_UNDERRUN]));
        rd(mtx_pkg::OFF_COLL_COUNT, v);
        if (ecnt != 8'hff)
            chk(10'(v), 10'(ecnt));
    endtask

    initial
    begin
        logic [7:0] v;
        int m;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        #1;
        chk(10'(crc_append), 10'h001);
        chk(10'(loopback_mode), 10'h000);
        chk(10'(loopback_output_pin), 10'h000);
        // every loopback code with both crc settings, loopback allowed
        loopback_select_enable <= 1'b0;
        for (m = 0; m < 8; m++)
        begin
            wr(mtx_pkg::OFF_TX_CONFIG, 8'(m));
            chk(10'(loopback_mode), 10'(m >> 1));
            chk(10'(loopback_output_pin), 10'(m >> 1 == 2));
            chk(10'(crc_append), 10'(m % 2 == 0));
        end
        // data config bit set forces normal mode whatever the field holds
        loopback_select_enable <= 1'b1;
        wr(mtx_pkg::OFF_TX_CONFIG, 8'he4);
        chk(10'(loopback_mode), 10'h000);
        chk(10'(loopback_output_pin), 10'h000);
        chk(10'(crc_append), 10'h001);
        loopback_select_enable <= 1'b0;
        tick();
        chk(10'(loopback_output_pin), 10'h001);
        loopback_select_enable <= 1'b1;
        rd(mtx_pkg::OFF_TX_CONFIG, v);
        chk(10'(v), 10'h000);
        rd(8'h07, v);
        chk(10'(v), 10'h000);
        wr(mtx_pkg::OFF_TX_CONFIG, 8'h00);
        // frames: collisions, {heartbeat, carrier drop, late}, underrun, status, count
        frame(5'h00, 3'b100, 1'b0, 8'h01, 8'h00);
        frame(5'h00, 3'b000, 1'b0, 8'h41, 8'h00);
        frame(5'h00, 3'b110, 1'b0, 8'h11, 8'h00);
        frame(5'h03, 3'b100, 1'b0, 8'h05, 8'h03);
        chk(10'(mx_seen < 10'h008), 10'h001);
        wr(mtx_pkg::OFF_TX_CONFIG, 8'h10);
        frame(5'h03, 3'b100, 1'b0, 8'h05, 8'h03);
        chk(10'(mx_seen < 10'h040), 10'h001);
        frame(5'h00, 3'b100, 1'b0, 8'h01, 8'h00);
        frame(5'h01, 3'b101, 1'b0, 8'h85, 8'h01);
        wr(mtx_pkg::OFF_TX_CONFIG, 8'h00);
        frame(5'h10, 3'b100, 1'b0, 8'h0c, 8'h10);
        frame(5'h00, 3'b100, 1'b1, 8'h20, 8'h00);
        // remote transmitter control by multicast hash
        hash(mtx_pkg::HASH_DISABLE);
        chk(10'(tx_enable), 10'h001);
        wr(mtx_pkg::OFF_TX_CONFIG, 8'h08);
        hash(mtx_pkg::HASH_DISABLE);
        chk(10'(tx_enable), 10'h000);
        @(posedge clk_sys);
        tx_start <= 1'b1;
        @(posedge clk_sys);
        tx_start <= 1'b0;
        tick();
        chk(10'(tx_busy), 10'h000);
        hash(mtx_pkg::HASH_ENABLE);
        chk(10'(tx_enable), 10'h001);
        hash(mtx_pkg::HASH_DISABLE);
        wr(mtx_pkg::OFF_TX_CONFIG, 8'h00);
        chk(10'(tx_enable), 10'h001);
        report_and_stop();
    end
endmodule // tb_top
